// >>> hdl/kli_keypad_level_interrupt.sv
// keypad level interrupt: eight sticky level flags on a port, apb register slave
// Function
// - flag line when pin shows programmed level
// - enabled flags ORed into one shared request
// - flags stay set until software clears
// - writes to flag register ignored
// - flag register read returns then clears all
// - disabled line stays plain I/O, no request
// - enabled line flag drives interrupt request
// - reset clears flags and enable register
// - level select zero low, one high
// - global enable gates combined keypad request
// - eight independent sources, one shared vector
// - detected level wakes from idle, power-down
`timescale 1ns/100ps
module kli_keypad_level_interrupt
  import kli_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port pins and pin mode
  input  wire logic [7:0]  port_pin_in,
  output logic      [7:0]  line_is_keypad,
  // interrupt and wake outputs
  output logic             keypad_irq_req,
  output logic             keypad_wake,
  output logic             irq
);

  // all state of the block except the reset synchroniser
  typedef struct packed {
    logic [7:0]  level_sel;   // detected level per line
    logic [7:0]  line_en;     // per-line enable
    logic [7:0]  line_flags;  // sticky detection flags
    logic        gie;         // global keypad enable
    logic [1:0]  stat;        // sticky interrupt status
    logic [1:0]  mask;        // interrupt mask
    logic        req_q;       // registered gated keypad request
    logic        wake_q;      // registered wake request
  } kli_state_s;

  kli_state_s st_q;           // registered state
  kli_state_s st_d;           // next state
  logic [1:0] rst_sync_q;     // reset release synchroniser
  logic       rst_n;          // synchronised reset
  logic [7:0] detect;         // per-line level match
  logic [7:0] line_req;       // per-line enabled request
  logic       access;         // apb access phase
  logic       wr_en;          // write strobe
  logic       rd_en;          // read strobe
  logic       mapped;         // address hits a register

  // address decode used by the error answer; the read mux decodes paddr itself
  // exact match only: aliases would let a stray read clear the flags
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == KLI_ADDR_LEVEL_SEL) || (a == KLI_ADDR_LINE_EN) ||
                (a == KLI_ADDR_LINE_FLAGS) || (a == KLI_ADDR_CTRL) ||
                (a == KLI_ADDR_IRQ_STAT) || (a == KLI_ADDR_IRQ_MASK);
  endfunction

  // reset released through two flops, asserted at once
  // release is synchronous so no flop sees reset leave mid-cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // per-line level compare and enable gating
  // one slice per port line, all lines alike and independent
  genvar gi;
  generate
    for (gi = 0; gi < KLI_NLINES; gi++)
    begin : g_line
      // high select matches high pin, low select matches low pin
      assign detect[gi]   = (port_pin_in[gi] == st_q.level_sel[gi]);
      // disabled lines never reach the shared request
      assign line_req[gi] = st_q.line_flags[gi] & st_q.line_en[gi];
    end
  endgenerate

  // apb strobes, zero wait state
  assign access  = psel & penable;
  assign wr_en   = access & pwrite;
  assign rd_en   = access & ~pwrite;
  assign mapped  = is_mapped(paddr);
  // no wait states: every register answers in the access cycle
  assign pready  = 1'b1;
  // unmapped offsets answer with an error but change nothing
  assign pslverr = access & ~mapped;

  // next-state logic
  always_comb
  begin
    st_d = st_q;
    // prdata is a mux of registered state, so no read flop is needed
    // flags: read clears all, new detections win over the clear
    // a level still held at the read sets its flag again at once
    if (rd_en && paddr == KLI_ADDR_LINE_FLAGS)
    begin
      st_d.line_flags = detect;
    end
    else
    begin
      st_d.line_flags = st_q.line_flags | detect;
    end
    // register writes; flag register has no write path
    // eight-bit registers take the low byte, upper bits dropped
    if (wr_en)
    begin
      unique case (paddr)
        KLI_ADDR_LEVEL_SEL: st_d.level_sel = pwdata[7:0];
        KLI_ADDR_LINE_EN:   st_d.line_en   = pwdata[7:0];
        KLI_ADDR_CTRL:      st_d.gie       = pwdata[KLI_CTRL_GIE_BIT];
        KLI_ADDR_IRQ_MASK:  st_d.mask      = pwdata[KLI_NSTAT-1:0];
        KLI_ADDR_IRQ_STAT:  st_d.stat      = st_q.stat & ~pwdata[KLI_NSTAT-1:0];
        KLI_ADDR_LINE_FLAGS: ;
        default:            ;
      endcase
    end
    // combined request gated by the global enable
    st_d.req_q  = (|line_req) & st_q.gie;
    // any enabled line seeing its level wakes the core, even without gie
    st_d.wake_q = |(detect & st_q.line_en);
    // sticky status, set wins over write-one-to-clear
    // so an event in the clearing cycle is never lost
    st_d.stat[KLI_STAT_KEY_BIT]  = st_d.stat[KLI_STAT_KEY_BIT] | st_q.req_q;
    st_d.stat[KLI_STAT_WAKE_BIT] = st_d.stat[KLI_STAT_WAKE_BIT] | st_q.wake_q;
  end

  // read mux, from registered state only
  always_comb
  begin
    prdata = 32'h0;
    if (rd_en)
    begin
      unique case (paddr)
        KLI_ADDR_LEVEL_SEL:  prdata = {24'h0, st_q.level_sel};
        KLI_ADDR_LINE_EN:    prdata = {24'h0, st_q.line_en};
        KLI_ADDR_LINE_FLAGS: prdata = {24'h0, st_q.line_flags};
        KLI_ADDR_CTRL:       prdata = {31'h0, st_q.gie};
        KLI_ADDR_IRQ_STAT:   prdata = {30'h0, st_q.stat};
        KLI_ADDR_IRQ_MASK:   prdata = {30'h0, st_q.mask};
        default:             prdata = 32'h0;
      endcase
    end
  end

  // single state register
  // reset branch loads constants only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.level_sel  <= KLI_RST_LEVEL_SEL;
      st_q.line_en    <= KLI_RST_LINE_EN;
      st_q.line_flags <= KLI_RST_LINE_FLAGS;
      st_q.gie        <= KLI_RST_GIE;
      st_q.stat       <= KLI_RST_STAT;
      st_q.mask       <= KLI_RST_MASK;
      st_q.req_q      <= 1'b0;
      st_q.wake_q     <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs, all from flops
  // irq is a plain and-or of flops, no extra delay
  assign line_is_keypad = st_q.line_en;
  assign keypad_irq_req = st_q.req_q;
  assign keypad_wake    = st_q.wake_q;
  assign irq            = |(st_q.stat & st_q.mask);

  // assertions
  // a set flag stays until a flag read
  sticky_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q.line_flags[0] && !(rd_en && paddr == KLI_ADDR_LINE_FLAGS)) |=> st_q.line_flags[0])
    else $error("flag dropped without a read");

  // a matching level sets the flag at the next edge
  detect_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (port_pin_in[3] == st_q.level_sel[3]) |=> st_q.line_flags[3])
    else $error("level not flagged");

  // a flag read with no level present leaves all flags clear
  read_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_en && paddr == KLI_ADDR_LINE_FLAGS && detect == 8'h00) |=> st_q.line_flags == 8'h00)
    else $error("flags not cleared by read");

  // a level seen during the clearing read survives it
  read_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_en && paddr == KLI_ADDR_LINE_FLAGS && detect[5]) |=> st_q.line_flags[5])
    else $error("detection lost on clearing read");

  // a write to the flags changes nothing beyond fresh detections
  no_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_LINE_FLAGS)
      |=> ((st_q.line_flags ^ $past(st_q.line_flags)) & ~$past(detect)) == 8'h00)
    else $error("flag register changed by write");

  // a request needs the global enable and an enabled flag
  req_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    keypad_irq_req |-> ($past(st_q.gie) && ($past(line_req) != 8'h00)))
    else $error("request without enabled flag");

  // no enabled line at all gives no request
  disabled_line_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q.line_en == 8'h00) |=> !keypad_irq_req)
    else $error("disabled lines raised request");

  // an enabled set flag raises the request
  enabled_req_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q.line_flags[2] && st_q.line_en[2] && st_q.gie) |=> keypad_irq_req)
    else $error("enabled flag gave no request");

  // global enable off blocks the request
  global_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_q.gie |=> !keypad_irq_req)
    else $error("request passed with global enable off");

  // an enabled line seeing its level wakes the core
  wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (detect[1] && st_q.line_en[1]) |=> keypad_wake)
    else $error("no wake on detected level");

  // flags and enables come out of reset clear
  reset_val_a: assert property (@(posedge core_clk)
    $rose(rst_n) |-> (st_q.line_flags == 8'h00 && st_q.line_en == 8'h00))
    else $error("reset values wrong");

  // a request with its mask bit set reaches irq
  irq_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (keypad_irq_req && st_q.mask[KLI_STAT_KEY_BIT] && !wr_en) |=> irq)
    else $error("masked-in request gave no irq");

  // enable register takes the written low byte
  en_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_LINE_EN)
      |=> ({24'h0, line_is_keypad} == ($past(pwdata) & 32'h0000_00ff)))
    else $error("enable write lost");

  // a flag read returns the flags as they stood
  flags_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_en && paddr == KLI_ADDR_LINE_FLAGS) |-> (prdata == {24'h0, st_q.line_flags}))
    else $error("flag read data wrong");

  // level select takes the written low byte
  level_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_LEVEL_SEL)
      |=> ({24'h0, st_q.level_sel} == ($past(pwdata) & 32'h0000_00ff)))
    else $error("level select write lost");

  // select zero: a low pin is flagged
  low_detect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!st_q.level_sel[0] && !port_pin_in[0]) |=> st_q.line_flags[0])
    else $error("low level not flagged");

  // select one: a high pin is flagged
  high_detect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q.level_sel[7] && port_pin_in[7]) |=> st_q.line_flags[7])
    else $error("high level not flagged");

  // a clear flag stays clear while its level is absent
  no_spurious_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!st_q.line_flags[4] && (port_pin_in[4] != st_q.level_sel[4])) |=> !st_q.line_flags[4])
    else $error("flag set without its level");

  // wake only follows an enabled detection
  wake_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    keypad_wake |-> (($past(detect) & $past(st_q.line_en)) != 8'h00))
    else $error("wake without enabled detection");

  // key status stays until written with a one
  stat_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q.stat[KLI_STAT_KEY_BIT] && !(wr_en && paddr == KLI_ADDR_IRQ_STAT))
      |=> st_q.stat[KLI_STAT_KEY_BIT])
    else $error("key status dropped");

  // a request sets key status even against a clear
  stat_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    keypad_irq_req |=> st_q.stat[KLI_STAT_KEY_BIT])
    else $error("request not recorded");

  // enables and flags held clear during reset
  reset_en_a: assert property (@(posedge core_clk)
    !rst_n |-> (st_q.line_en == 8'h00 && st_q.line_flags == 8'h00))
    else $error("state not clear in reset");

  // control write sets the global enable
  gie_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_CTRL) |=> ({31'h0, st_q.gie} == ($past(pwdata) & 32'h1)))
    else $error("global enable write lost");

  // a write to the flags is dropped without an error
  flag_write_ok_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_LINE_FLAGS) |-> !pslverr)
    else $error("flag write answered with error");

  // mask register takes the written bits
  mask_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_IRQ_MASK) |=> ({30'h0, st_q.mask} == ($past(pwdata) & 32'h3)))
    else $error("mask write lost");

  // writing one clears wake status when no wake is pending
  w1c_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && paddr == KLI_ADDR_IRQ_STAT && pwdata[KLI_STAT_WAKE_BIT] && !keypad_wake)
      |=> !st_q.stat[KLI_STAT_WAKE_BIT])
    else $error("wake status not cleared");

  // no enabled flag gives no request
  req_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (line_req == 8'h00) |=> !keypad_irq_req)
    else $error("request without any enabled flag");

  // unmapped reads answer zero with an error
  unmapped_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_en && !mapped) |-> (prdata == 32'h0 && pslverr))
    else $error("unmapped read answered wrongly");

  // covers
  cov_read_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_q.line_flags != 8'h00 ##1 (rd_en && paddr == KLI_ADDR_LINE_FLAGS));
  cov_req_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(keypad_irq_req));
  cov_irq_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));
  cov_wake_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(keypad_wake));
  cov_keep_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    (rd_en && paddr == KLI_ADDR_LINE_FLAGS && detect != 8'h00));

endmodule

// >>> hdl/kli_pkg.sv
// package: register map, field layout and reset values of the keypad level interrupt block
package kli_pkg;
  // register byte offsets (printed offsets are not multiples of four, so index * 4)
  localparam logic [7:0]  KLI_IDX_LEVEL_SEL  = 8'h9c;
  localparam logic [7:0]  KLI_IDX_LINE_EN    = 8'h9d;
  localparam logic [7:0]  KLI_IDX_LINE_FLAGS = 8'h9e;
  localparam logic [11:0] KLI_ADDR_LEVEL_SEL  = {2'h0, KLI_IDX_LEVEL_SEL, 2'h0};
  localparam logic [11:0] KLI_ADDR_LINE_EN    = {2'h0, KLI_IDX_LINE_EN, 2'h0};
  localparam logic [11:0] KLI_ADDR_LINE_FLAGS = {2'h0, KLI_IDX_LINE_FLAGS, 2'h0};
  // own control and interrupt registers
  localparam logic [11:0] KLI_ADDR_CTRL      = 12'h400;
  localparam logic [11:0] KLI_ADDR_IRQ_STAT  = 12'h404;
  localparam logic [11:0] KLI_ADDR_IRQ_MASK  = 12'h408;
  // field positions
  localparam int KLI_NLINES        = 8;
  localparam int KLI_CTRL_GIE_BIT  = 0;
  localparam int KLI_STAT_KEY_BIT  = 0;
  localparam int KLI_STAT_WAKE_BIT = 1;
  localparam int KLI_NSTAT         = 2;
  // reset values
  localparam logic [7:0] KLI_RST_LEVEL_SEL  = 8'h00;
  localparam logic [7:0] KLI_RST_LINE_EN    = 8'h00;
  localparam logic [7:0] KLI_RST_LINE_FLAGS = 8'h00;
  localparam logic [1:0] KLI_RST_STAT       = 2'h0;
  localparam logic [1:0] KLI_RST_MASK       = 2'h0;
  localparam logic       KLI_RST_GIE        = 1'b0;
endpackage

// >>> testbench/kli_key_matrix.sv
// key matrix model: switches that pull port lines low against pull-ups
`timescale 1ns/100ps
module kli_key_matrix
(
  // keys held down by the bench
  input  wire logic [7:0] key_down,
  // port lines seen by the block
  output logic      [7:0] port_lines
);
  // a released key leaves its line at the pull-up level, never floating
  assign port_lines = ~key_down;
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the keypad level interrupt block
`timescale 1ns/100ps
module testbench;
  import kli_pkg::*;
  logic        core_clk = 1'b0;        // 25 MHz core clock
  logic        resetn   = 1'b0;        // active low reset
  logic        psel     = 1'b0;        // apb select
  logic        penable  = 1'b0;        // apb access phase
  logic        pwrite   = 1'b0;        // apb direction
  logic [11:0] paddr    = 12'h000;     // apb byte address
  logic [31:0] pwdata   = 32'h0;       // apb write data
  logic [31:0] prdata;                 // apb read data
  logic        pready, pslverr;        // apb answer
  logic [7:0]  key_down = 8'h00;       // keys pressed on the matrix
  logic [7:0]  port_pin_in, line_is_keypad;
  logic        keypad_irq_req, keypad_wake, irq;
  logic [32:0] exq[$];                 // expected {pslverr, prdata} of reads
  logic [15:0] seed = 16'd34943;       // xorshift state
  logic [7:0]  m;                      // random key mask
  int          num_errors = 0;
  int          num_checks = 0;
  // clock: half period 20 ns
  always #20 core_clk = ~core_clk;
  kli_key_matrix kli_key_matrix_i (.key_down(key_down), .port_lines(port_pin_in));
  kli_keypad_level_interrupt kli_keypad_level_interrupt_i (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pin_in(port_pin_in),
    .line_is_keypad(line_is_keypad), .keypad_irq_req(keypad_irq_req),
    .keypad_wake(keypad_wake), .irq(irq));
  // xorshift generator, fixed start value keeps runs repeatable
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  // one compare, counted
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // apb transfer; reads note their expectation for the watcher
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) exq.push_back(e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never lands in the same time step
    @(posedge core_clk);
  endtask
  // watcher: read data is taken at the edge that ends the access
  always @(posedge core_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      chk({pslverr, prdata}, exq.pop_front());
    end
  end
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog well beyond the 120 or so cycles the sequence needs
  initial
  begin
    #(40 * 5000);
    num_errors++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, KLI_ADDR_LINE_EN, 32'h0, 33'h0);
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'h0);
    apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
    apb(1'b1, KLI_ADDR_CTRL, 32'h1, 33'h0);
    apb(1'b1, KLI_ADDR_LINE_EN, 32'h0f, 33'h0);
    // disabled line flags but stays out of the request
    // outputs are looked at on the falling edge, where they are settled
    key_down <= 8'h40;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(keypad_irq_req, 1'b0);
    chk(line_is_keypad, 8'h0f);
    @(posedge core_clk);
    key_down <= 8'h00;
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'h40);
    // enabled line raises request and wake
    key_down <= 8'h04;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(keypad_wake, 1'b1);
    @(posedge core_clk);
    key_down <= 8'h00;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(keypad_irq_req, 1'b1);
    @(posedge core_clk);
    apb(1'b1, KLI_ADDR_IRQ_MASK, 32'h1, 33'h0);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(irq, 1'b1);
    @(posedge core_clk);
    apb(1'b1, KLI_ADDR_CTRL, 32'h0, 33'h0);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(keypad_irq_req, 1'b0);
    @(posedge core_clk);
    apb(1'b1, KLI_ADDR_IRQ_MASK, 32'h0, 33'h0);
    @(negedge core_clk);
    chk(irq, 1'b0);
    @(posedge core_clk);
    // writes to the flag register are dropped, read clears
    apb(1'b1, KLI_ADDR_LINE_FLAGS, 32'hff, 33'h0);
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'h04);
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'h0);
    apb(1'b1, KLI_ADDR_IRQ_STAT, 32'h3, 33'h0);
    apb(1'b0, KLI_ADDR_IRQ_STAT, 32'h0, 33'h0);
    // high level on idle lines: held level survives the clearing read
    apb(1'b1, KLI_ADDR_LEVEL_SEL, 32'hff, 33'h0);
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'hff);
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'hff);
    apb(1'b1, KLI_ADDR_LEVEL_SEL, 32'h0, 33'h0);
    apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, 33'hff);
    // random key sets, each line flags on its own
    repeat (4)
    begin
      m = 8'(xs());
      key_down <= m;
      repeat (2) @(posedge core_clk);
      key_down <= 8'h00;
      repeat (2) @(posedge core_clk);
      apb(1'b0, KLI_ADDR_LINE_FLAGS, 32'h0, {25'h0, m});
    end
    end_sim();
  end
endmodule
